// file: ipb_pkg.sv
// ipb_pkg: register map, field layout and reset values of the upper
// interrupt priority bank; shared by the bus slave, the registers and the top.
package ipb_pkg;

  // bus geometry
  localparam int          IPB_ADDR_W   = 8;
  localparam int          IPB_DATA_W   = 32;
  localparam int          IPB_REG_W    = 16;
  localparam int          IPB_NREG     = 7;
  localparam int          IPB_NSRC     = 15;
  localparam int          IPB_PRIO_W   = 3;

  // byte offsets of the seven priority registers
  localparam logic [7:0]  IPB_OFF_A    = 8'h00;
  localparam logic [7:0]  IPB_OFF_B    = 8'h04;
  localparam logic [7:0]  IPB_OFF_C    = 8'h08;
  localparam logic [7:0]  IPB_OFF_D    = 8'h0C;
  localparam logic [7:0]  IPB_OFF_E    = 8'h10;
  localparam logic [7:0]  IPB_OFF_F    = 8'h14;
  localparam logic [7:0]  IPB_OFF_G    = 8'h18;
  localparam logic [7:0]  IPB_OFF [IPB_NREG] = '{IPB_OFF_A, IPB_OFF_B, IPB_OFF_C, IPB_OFF_D,
                                                 IPB_OFF_E, IPB_OFF_F, IPB_OFF_G};

  // implemented bits per register; everything else is stuck at zero
  localparam logic [15:0] IPB_MASK [IPB_NREG] = '{16'h7777, 16'h0077, 16'h0770, 16'h0770,
                                                  16'h0700, 16'h7770, 16'h0007};
  // each field resets to 3'b100, priority level 4
  localparam logic [15:0] IPB_RST  [IPB_NREG] = '{16'h4444, 16'h0044, 16'h0440, 16'h0440,
                                                  16'h0400, 16'h4440, 16'h0004};

  // source order: compare7, compare6, compare5, capture6, parallel port, compare8,
  // twowire2 master, twowire2 slave, ext irq4, ext irq3, calendar, checksum error,
  // serial2 error, serial1 error, low voltage
  localparam int IPB_SRC_REG [IPB_NSRC] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 5, 5, 5, 6};
  localparam int IPB_SRC_LSB [IPB_NSRC] = '{12, 8, 4, 0, 4, 0, 8, 4, 8, 4, 8, 12, 8, 4, 0};

  // priority codes
  localparam logic [2:0]  IPB_PRIO_OFF = 3'h0;
  localparam logic [2:0]  IPB_PRIO_MIN = 3'h1;
  localparam logic [2:0]  IPB_PRIO_MAX = 3'h7;
  localparam logic [2:0]  IPB_PRIO_RST = 3'h4;

endpackage

// file: ipb_prio_reg.sv
// ipb_prio_reg: one 16-bit priority register with implemented-bit mask,
// byte-lane writes and reset value; assumes a single-cycle write strobe.
`timescale 1ns/1ps
module ipb_prio_reg
  import ipb_pkg::*;
#(
  parameter logic [15:0] RST  = 16'h0000,
  parameter logic [15:0] MASK = 16'h0000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_lane,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] value,
  output logic      [15:0] next_value
);

  typedef struct packed {
    logic [15:0] val;
  } ipb_reg_state_type;

  ipb_reg_state_type r_q;
  ipb_reg_state_type r_d;

  // a reset value outside the mask would show bits that read one until their lane is written
  if ((RST & ~MASK) != 16'h0000) begin : g_bad_rst
    $error("reset value sets unimplemented bits");
  end

  // unused bits never take a write, so they always read zero
  always_comb begin
    r_d = r_q;
    if (wr_en && wr_lane[0]) begin
      r_d.val[7:0] = wr_data[7:0] & MASK[7:0];
    end
    if (wr_en && wr_lane[1]) begin
      r_d.val[15:8] = wr_data[15:8] & MASK[15:8];
    end
    next_value = r_d.val;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q.val <= RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign value = r_q.val;

endmodule // ipb_prio_reg

// file: ipb_apb_slave.sv
// ipb_apb_slave: APB slave front end with one wait state; decodes the
// seven register words, registers read data and flags unmapped addresses.
`timescale 1ns/1ps
module ipb_apb_slave
  import ipb_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [IPB_ADDR_W-1:0] paddr,
  input  wire logic [15:0]           rd_word [IPB_NREG],
  output logic      [IPB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic      [IPB_NREG-1:0]   wr_sel
);

  typedef struct packed {
    logic [IPB_DATA_W-1:0] rdata;
    logic                  ready;
    logic                  err;
  } ipb_apb_state_type;

  ipb_apb_state_type s_q;
  ipb_apb_state_type s_d;

  // one-hot word select; misaligned or unlisted addresses select nothing
  function automatic logic [IPB_NREG-1:0] decode(input logic [IPB_ADDR_W-1:0] a);
    logic [IPB_NREG-1:0] hit;
    hit = '0;
    for (int i = 0; i < IPB_NREG; i++) begin
      hit[i] = (a == IPB_OFF[i]);
    end
    return hit;
  endfunction

  logic [IPB_NREG-1:0] hit;
  logic                access;

  // ready is raised one cycle into the access phase so read data is a flop
  always_comb begin
    hit    = decode(paddr);
    access = psel && penable;
    s_d    = s_q;
    s_d.ready = access && !s_q.ready;
    s_d.err   = access && !s_q.ready && (hit == '0);
    if (access && !s_q.ready) begin
      s_d.rdata = '0;
      for (int i = 0; i < IPB_NREG; i++) begin
        if (hit[i] && !pwrite) begin
          s_d.rdata[15:0] = rd_word[i];
        end
      end
    end
    wr_sel = (access && s_q.ready && pwrite) ? hit : '0;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.rdata;
  assign pready  = s_q.ready;
  assign pslverr = s_q.err;

endmodule // ipb_apb_slave

// file: ipb_bank.sv
// ipb_bank: upper interrupt priority bank, seven software registers that
// hold 3-bit priorities for fifteen sources, read and written over APB.
// Assumes the arbiter samples the priority outputs on pclk.
//
// Summary of operation
// - field 3'b111 means priority 7, the highest level
// - field 3'b000 disables its source; it is never granted
// - field 3'b001 is level 1, codes 2 to 6 map linearly
// - unused bits ignore writes and read as zero
// - after reset every field reads 3'b100, level 4
// - implemented bits are read/write and read back the last write
// - set a: compare7 14-12, compare6 10-8, compare5 6-4, capture6 2-0
// - set b: parallel port 6-4, compare8 2-0, bits 15-7 unused
// - set c: twowire2 master 10-8, twowire2 slave 6-4
// - set d: ext irq4 10-8, ext irq3 6-4
// - set e: calendar 10-8, other bits unused
// - set f: checksum error 14-12, serial2 error 10-8, serial1 error 6-4
// - set g: low voltage 2-0, bits 15-3 unused
`timescale 1ns/1ps
module ipb_bank
  import ipb_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [IPB_ADDR_W-1:0] paddr,
  input  wire logic [IPB_DATA_W-1:0] pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [IPB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic      [2:0]            compare7_priority,
  output logic      [2:0]            compare6_priority,
  output logic      [2:0]            compare5_priority,
  output logic      [2:0]            capture6_priority,
  output logic      [2:0]            parallel_port_priority,
  output logic      [2:0]            compare8_priority,
  output logic      [2:0]            twowire2_master_priority,
  output logic      [2:0]            twowire2_slave_priority,
  output logic      [2:0]            ext_irq4_priority,
  output logic      [2:0]            ext_irq3_priority,
  output logic      [2:0]            calendar_priority,
  output logic      [2:0]            checksum_error_priority,
  output logic      [2:0]            serial2_error_priority,
  output logic      [2:0]            serial1_error_priority,
  output logic      [2:0]            low_voltage_priority,
  output logic      [IPB_NSRC-1:0]   source_live,
  output logic      [2:0]            top_level
);

  typedef struct packed {
    logic [IPB_NSRC-1:0] live;
    logic [2:0]          top;
    logic                first;
  } ipb_bank_state_type;

  ipb_bank_state_type b_q;
  ipb_bank_state_type b_d;

  logic [15:0]         reg_q  [IPB_NREG];
  logic [15:0]         reg_nx [IPB_NREG];
  logic [IPB_NREG-1:0] wr_sel;
  logic [2:0]          prio_nx [IPB_NSRC];

  // pull one 3-bit field out of a register word
  function automatic logic [2:0] field(input logic [15:0] w, input int lsb);
    logic [15:0] sh;
    sh = w >> lsb;
    return sh[2:0];
  endfunction

  // bus front end
  ipb_apb_slave u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .rd_word (reg_q),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_sel  (wr_sel)
  );

  // the seven priority registers, each with its own mask and reset value
  for (genvar g = 0; g < IPB_NREG; g++) begin : g_reg
    ipb_prio_reg #(
      .RST  (IPB_RST[g]),
      .MASK (IPB_MASK[g])
    ) u_reg (
      .pclk       (pclk),
      .presetn    (presetn),
      .wr_en      (wr_sel[g]),
      .wr_lane    (pstrb[1:0]),
      .wr_data    (pwdata[15:0]),
      .value      (reg_q[g]),
      .next_value (reg_nx[g])
    );
  end

  // field wiring straight from the register flops, so a write shows next cycle
  assign compare7_priority        = field(reg_q[0], IPB_SRC_LSB[0]);
  assign compare6_priority        = field(reg_q[0], IPB_SRC_LSB[1]);
  assign compare5_priority        = field(reg_q[0], IPB_SRC_LSB[2]);
  assign capture6_priority        = field(reg_q[0], IPB_SRC_LSB[3]);
  assign parallel_port_priority   = field(reg_q[1], IPB_SRC_LSB[4]);
  assign compare8_priority        = field(reg_q[1], IPB_SRC_LSB[5]);
  assign twowire2_master_priority = field(reg_q[2], IPB_SRC_LSB[6]);
  assign twowire2_slave_priority  = field(reg_q[2], IPB_SRC_LSB[7]);
  assign ext_irq4_priority        = field(reg_q[3], IPB_SRC_LSB[8]);
  assign ext_irq3_priority        = field(reg_q[3], IPB_SRC_LSB[9]);
  assign calendar_priority        = field(reg_q[4], IPB_SRC_LSB[10]);
  assign checksum_error_priority  = field(reg_q[5], IPB_SRC_LSB[11]);
  assign serial2_error_priority   = field(reg_q[5], IPB_SRC_LSB[12]);
  assign serial1_error_priority   = field(reg_q[5], IPB_SRC_LSB[13]);
  assign low_voltage_priority     = field(reg_q[6], IPB_SRC_LSB[14]);

  // live flags and the highest level are built from next values so that
  // they change in the same cycle as the priority outputs themselves
  always_comb begin
    b_d       = b_q;
    b_d.first = 1'b0;
    b_d.top   = IPB_PRIO_OFF;
    for (int i = 0; i < IPB_NSRC; i++) begin
      prio_nx[i]  = field(reg_nx[IPB_SRC_REG[i]], IPB_SRC_LSB[i]);
      b_d.live[i] = (prio_nx[i] != IPB_PRIO_OFF);
      // the code is the level itself: 7 highest, 1 lowest active
      if (prio_nx[i] > b_d.top) begin
        b_d.top = prio_nx[i];
      end
    end
  end

  // state register; reset values match the register reset of level 4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_q.live  <= '1;
      b_q.top   <= IPB_PRIO_RST;
      b_q.first <= 1'b1;
    end else begin
      b_q <= b_d;
    end
  end

  assign source_live = b_q.live;
  assign top_level   = b_q.top;

  // ---- assertions ----------------------------------------------------------

  logic [2:0] prio_q [IPB_NSRC];
  logic       rd_done;
  logic       wr_done;
  logic [IPB_NSRC-1:0] live_ref;
  logic [2:0]          top_ref;
  logic [15:0]         lane_bits;
  logic [15:0]         wr_expect [IPB_NREG];

  always_comb begin
    prio_q = '{compare7_priority, compare6_priority, compare5_priority,
               capture6_priority, parallel_port_priority, compare8_priority,
               twowire2_master_priority, twowire2_slave_priority,
               ext_irq4_priority, ext_irq3_priority, calendar_priority,
               checksum_error_priority, serial2_error_priority,
               serial1_error_priority, low_voltage_priority};
    rd_done = psel && penable && pready && !pwrite && !pslverr;
    wr_done = psel && penable && pready && pwrite && !pslverr;
    // reference taken from the output pins, not from the next-value path,
    // so a slip in the registered live/top logic cannot hide itself
    top_ref = IPB_PRIO_OFF;
    for (int i = 0; i < IPB_NSRC; i++) begin
      live_ref[i] = (prio_q[i] != IPB_PRIO_OFF);
      if (prio_q[i] > top_ref) begin
        top_ref = prio_q[i];
      end
    end
    // word a write must leave behind: lane by lane, then masked
    lane_bits = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    for (int w = 0; w < IPB_NREG; w++) begin
      wr_expect[w] = ((pwdata[15:0] & lane_bits) | (reg_q[w] & ~lane_bits)) & IPB_MASK[w];
    end
  end

  // a read that completes at a given register word
  sequence s_read_at(logic [IPB_ADDR_W-1:0] off);
    rd_done && (paddr == off);
  endsequence

  // a full-width write that completes at a given register word
  sequence s_write_at(logic [IPB_ADDR_W-1:0] off);
    wr_done && (paddr == off) && (pstrb[1:0] == 2'h3);
  endsequence

  a_reset_default: assert property (@(posedge pclk) disable iff (!presetn)
    b_q.first |-> (compare7_priority == IPB_PRIO_RST) && (low_voltage_priority == IPB_PRIO_RST)
                  && (reg_q[2] == IPB_RST[2]) && (top_level == IPB_PRIO_RST))
    else $error("priority fields not at level 4 after reset");

  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done |-> (prdata[31:16] == 16'h0000)
                && ((prdata[15:0] & ~IPB_MASK[(paddr >> 2) % IPB_NREG]) == 16'h0000))
    else $error("unused bit read back as one");

  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_at(IPB_OFF_F) |=> (reg_q[5] == ($past(pwdata[15:0]) & IPB_MASK[5]))
                              ##1 (reg_q[5] == $past(reg_q[5])) or (wr_sel[5]))
    else $error("written value not held in set f");

  a_write_stable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_sel == '0) |=> $stable(compare7_priority) && $stable(calendar_priority)
                       && $stable(low_voltage_priority))
    else $error("priority changed with no write");

  a_write_timing: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_at(IPB_OFF_G) |=> (low_voltage_priority == $past(pwdata[2:0])))
    else $error("low voltage priority not updated one cycle after write");

  a_disabled_dead: assert property (@(posedge pclk) disable iff (!presetn)
    (calendar_priority == IPB_PRIO_OFF) |-> !source_live[10] && (compare8_priority != IPB_PRIO_OFF
                                                                == source_live[5]))
    else $error("live flag disagrees with zero priority");

  a_top_level: assert property (@(posedge pclk) disable iff (!presetn)
    (serial1_error_priority == IPB_PRIO_MAX) |-> (top_level == IPB_PRIO_MAX))
    else $error("priority 7 source not reported as highest");

  a_low_level: assert property (@(posedge pclk) disable iff (!presetn)
    (source_live == '0) |-> (top_level == IPB_PRIO_OFF) && (prio_q[14] == IPB_PRIO_OFF))
    else $error("level reported with every source disabled");

  a_layout_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_at(IPB_OFF_A) |-> (prdata[14:12] == compare7_priority) && (prdata[10:8] == compare6_priority)
                             && (prdata[6:4] == compare5_priority) && (prdata[2:0] == capture6_priority))
    else $error("set a field layout wrong");

  a_layout_b: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_at(IPB_OFF_B) |-> (prdata[6:4] == parallel_port_priority)
                             && (prdata[2:0] == compare8_priority) && (prdata[15:7] == 9'h000))
    else $error("set b field layout wrong");

  a_layout_c: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_at(IPB_OFF_C) |-> (prdata[10:8] == twowire2_master_priority)
                             && (prdata[6:4] == twowire2_slave_priority))
    else $error("set c field layout wrong");

  a_layout_d: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_at(IPB_OFF_D) |-> (prdata[10:8] == ext_irq4_priority) && (prdata[6:4] == ext_irq3_priority)
                             && (prdata[3:0] == 4'h0))
    else $error("set d field layout wrong");

  a_layout_e: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_at(IPB_OFF_E) |-> (prdata[10:8] == calendar_priority) && (prdata[7:0] == 8'h00))
    else $error("set e field layout wrong");

  a_layout_f: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_at(IPB_OFF_F) |-> (prdata[14:12] == checksum_error_priority)
                             && (prdata[10:8] == serial2_error_priority)
                             && (prdata[6:4] == serial1_error_priority))
    else $error("set f field layout wrong");

  a_layout_g: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_at(IPB_OFF_G) |-> (prdata[2:0] == low_voltage_priority) && (prdata[15:3] == 13'h0000))
    else $error("set g field layout wrong");

  a_live_match: assert property (@(posedge pclk) disable iff (!presetn)
    (prio_q[0] != IPB_PRIO_OFF) == source_live[0])
    else $error("compare7 live flag out of step with its priority");

  // every register: a completed write leaves the lane-merged, masked word,
  // and no unimplemented bit can ever be seen set
  for (genvar g = 0; g < IPB_NREG; g++) begin : g_reg_chk
    a_write_each: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && (paddr == IPB_OFF[g]) |=> (reg_q[g] == $past(wr_expect[g])))
      else $error("register word differs from the lane-merged write");

    a_unused_each: assert property (@(posedge pclk) disable iff (!presetn)
      (reg_q[g] & ~IPB_MASK[g]) == 16'h0000)
      else $error("unimplemented register bit set");
  end

  // registered arbiter outputs against the pins they summarise
  a_top_match: assert property (@(posedge pclk) disable iff (!presetn)
    top_level == top_ref)
    else $error("top level differs from highest source priority");

  a_live_all: assert property (@(posedge pclk) disable iff (!presetn)
    source_live == live_ref)
    else $error("live flags differ from nonzero priorities");

  // code 1 alone must still count as an active level, the lowest one
  a_lowest_active: assert property (@(posedge pclk) disable iff (!presetn)
    (source_live == 15'h4000) && (low_voltage_priority == IPB_PRIO_MIN)
    |-> (top_level == IPB_PRIO_MIN))
    else $error("level 1 source not reported as lowest active level");

  // bus handshake: a setup cycle followed by the first access cycle
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence

  // one wait state keeps read data a flop; the master must not assume less
  a_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_access |-> !pready ##1 pready)
    else $error("ready not raised in the second access cycle");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  // a refused access never reaches a register
  a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && (wr_sel == '0))
    else $error("error response without ready or with a register write");

  // registers change only at the completing edge of a write
  a_write_only_done: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_sel != '0) |-> wr_done)
    else $error("register write outside a completed write transfer");

  a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |=> $stable(prdata))
    else $error("read data changed with no access");

endmodule // ipb_bank

// file: tb.sv
// tb: self-checking bench for the upper interrupt priority bank; drives the APB port
// and checks read data, per-source priorities, source_live and top_level against a model.
// Assumes ipb_pkg is compiled first and ipb_bank answers with one wait state.
`timescale 1ns/1ps
module tb;
  import ipb_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [44:0] prio_bus;
  logic [14:0] source_live;
  logic [2:0]  top_level;
  logic [15:0] model [7];
  logic [15:0] mask  [7];
  int          num_errors;
  int          compares;
  // field positions per source, bit order of source_live
  int          src_reg [15] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 5, 5, 5, 6};
  int          src_lsb [15] = '{12, 8, 4, 0, 4, 0, 8, 4, 8, 4, 8, 12, 8, 4, 0};

  ipb_bank u_dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .compare7_priority        (prio_bus[2:0]),
    .compare6_priority        (prio_bus[5:3]),
    .compare5_priority        (prio_bus[8:6]),
    .capture6_priority        (prio_bus[11:9]),
    .parallel_port_priority   (prio_bus[14:12]),
    .compare8_priority        (prio_bus[17:15]),
    .twowire2_master_priority (prio_bus[20:18]),
    .twowire2_slave_priority  (prio_bus[23:21]),
    .ext_irq4_priority        (prio_bus[26:24]),
    .ext_irq3_priority        (prio_bus[29:27]),
    .calendar_priority        (prio_bus[32:30]),
    .checksum_error_priority  (prio_bus[35:33]),
    .serial2_error_priority   (prio_bus[38:36]),
    .serial1_error_priority   (prio_bus[41:39]),
    .low_voltage_priority     (prio_bus[44:42]),
    .source_live              (source_live),
    .top_level                (top_level)
  );

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic give_verdict();
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // reset image: upper bit of every implemented field set, level 4
  task automatic load_reset();
    for (int r = 0; r < 7; r++) model[r] = mask[r] & 16'h4444;
  endtask

  // compare every arbiter-facing output with the model
  task automatic check_outputs();
    logic [2:0]  f;
    logic [2:0]  top;
    logic [14:0] live;
    top = 3'h0;
    for (int i = 0; i < 15; i++) begin
      f = model[src_reg[i]][src_lsb[i] +: 3];
      live[i] = (f != 3'h0);
      if (f > top) top = f;
      check(32'(prio_bus[3*i +: 3]), 32'(f));
    end
    check(32'(source_live), 32'(live));
    check(32'(top_level), 32'(top));
  endtask

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'($urandom), d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // write with byte lanes, then check outputs one cycle after completion
  task automatic wr(input int r, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 8'(4 * r), d, s, rd, err);
    check(32'(err), 32'h0);
    if (s[0]) model[r][7:0] = d[7:0] & mask[r][7:0];
    if (s[1]) model[r][15:8] = d[15:8] & mask[r][15:8];
    @(posedge pclk);
    #1 check_outputs();
  endtask

  task automatic rdchk(input int r);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, 8'(4 * r), 16'h0000, 4'h0, rd, err);
    check(rd, {16'h0000, model[r]});
    check(32'(err), 32'h0);
  endtask

  initial begin
    int          junk;
    logic [31:0] rd;
    logic        err;
    junk = $urandom(32'h31B185E3);
    foreach (mask[r]) mask[r] = 16'h0000;
    for (int i = 0; i < 15; i++) mask[src_reg[i]][src_lsb[i] +: 3] = 3'h7;
    load_reset();
    num_errors = 0;
    compares   = 0;
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    repeat (3) @(posedge pclk);
    #1 check_outputs();
    @(posedge pclk) presetn <= 1'b1;
    for (int r = 0; r < 7; r++) rdchk(r);
    // all ones: only implemented bits stick, every field at level 7
    for (int r = 0; r < 7; r++) wr(r, 16'hFFFF, 4'hF);
    for (int r = 0; r < 7; r++) rdchk(r);
    // all zeros disables every source
    for (int r = 0; r < 7; r++) wr(r, 16'h0000, 4'hF);
    // walk codes 1 to 7 on the only live source
    for (int c = 1; c < 8; c++) wr(6, 16'(c), 4'hF);
    // common nonzero level for all sources
    for (int r = 0; r < 7; r++) wr(r, 16'h3333, 4'hF);
    // unmapped and misaligned accesses are refused and change nothing
    apb(1'b1, 8'h05, 16'hFFFF, 4'hF, rd, err);
    check(32'(err), 32'h1);
    apb(1'b0, 8'h1C, 16'h0000, 4'h0, rd, err);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    #1 check_outputs();
    // random data and lane strobes across all registers
    for (int k = 0; k < 60; k++) begin
      wr(int'($urandom_range(6)), 16'($urandom), 4'($urandom));
      rdchk(int'($urandom_range(6)));
    end
    // reset in mid-run restores level 4 everywhere
    @(posedge pclk);
    presetn <= 1'b0;
    load_reset();
    #1 check_outputs();
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 7; r++) rdchk(r);
    give_verdict();
  end

endmodule // tb
